// ==== logic/bbfci_pkg.sv ====
/*
 * Constants, types and timing counts for the host-side flash command sequencer.
 * Assumes a 50 MHz bus clock and a byte/word-wide asynchronous flash on the far side.
 */
`default_nettype none

package bbfci_pkg;

    // ==========================================================
    // Clock and pin timing
    // ==========================================================
    localparam int CLK_MHZ = 50;
    localparam int T_WE_PULSE_NS = 50;
    localparam int T_ACCESS_NS = 80;
    localparam int T_RECOVER_NS = 30;
    localparam int SYNC_STAGES = 2;

    function automatic int ns_to_cycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [3:0] WE_CYCLES = 4'(ns_to_cycles(T_WE_PULSE_NS));
    // Input pins pass a synchroniser, so the read strobe stays low that much longer.
    localparam logic [3:0] RD_CYCLES = 4'(ns_to_cycles(T_ACCESS_NS) + SYNC_STAGES);
    localparam logic [3:0] REC_CYCLES = 4'(ns_to_cycles(T_RECOVER_NS));

    // ==========================================================
    // Flash command bytes
    // ==========================================================
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_A = 8'hD0;
    localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
    localparam logic [7:0] CMD_WRITE_SETUP_ALT = 8'h10;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    // Arbitrary default; the real byte belongs to the attached part.
    localparam logic [7:0] IDENTIFY_CMD_DEF = 8'h90;
    // Arbitrary default; the real byte belongs to the attached part.
    localparam logic [7:0] STATUS_CMD_DEF = 8'h70;

    // ==========================================================
    // Register map (byte offsets) and fields
    // ==========================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_BYTE = 8;
    localparam int CTRL_UNLOCK = 9;
    localparam int CTRL_PDOWN = 10;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_STALE = 3;

    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROGRAM = 3'h1,
        OP_ERASE = 3'h2,
        OP_IDENT = 3'h3,
        OP_STATUS = 3'h4,
        OP_ARRAY = 3'h5
    } bbfci_op_t;

    // Pins driven toward the flash.
    typedef struct packed {
        logic reset_powerdown_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic unlock;
        logic byte_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } bbfci_pins_t;

endpackage

`default_nettype wire

// ==== logic/bbfci_sync.sv ====
/*
 * Two-stage synchroniser for the flash data lines.
 * Assumes the data pins change asynchronously to hclk.
 */
`timescale 1ns/100ps
`default_nettype none

module bbfci_sync
    import bbfci_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // Data
    input wire logic [DATA_W-1:0] din,
    output logic [DATA_W-1:0] dout
);

    logic [DATA_W-1:0] meta_ff;
    logic [DATA_W-1:0] sync_ff;

    // ==========================================================
    // Synchroniser
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= 16'h0000;
            sync_ff <= 16'h0000;
        end else if (clk_en) begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;

endmodule // bbfci_sync

`default_nettype wire

// ==== logic/bbfci_host.sv ====
/*
 * Host-side flash command sequencer with an AHB-Lite register slave.
 * Assumes one asynchronous boot-block flash on the pins and a zero-wait bus.
 */
// Our own choices: the register addresses and the AHB-Lite slave port.
// Overview of operation
// - Erase is always the setup byte followed by the confirm byte.
// - Program is the write-setup byte immediately followed by address and data.
// - After non-array commands, read-array byte is sent before any array read.
// - Identify reads hold every address line low except line zero.
// - Array read: write strobe high, select and output enable low.
`timescale 1ns/100ps
`default_nettype none

module bbfci_host
    import bbfci_pkg::*;
#(
    parameter logic [7:0] IDENTIFY_CMD = IDENTIFY_CMD_DEF,
    parameter logic [7:0] STATUS_CMD = STATUS_CMD_DEF
)
(
    // Clock, reset and enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Flash pins
    output bbfci_pins_t flash_pins,
    input wire logic [DATA_W-1:0] flash_dq_in
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RECOVER
    } bbfci_state_t;

    // ==========================================================
    // Register storage
    // ==========================================================
    bbfci_state_t state_ff, nxt_state;
    bbfci_op_t op_ff;
    logic step_ff;
    logic [3:0] cnt_ff;
    logic byte_mode_ff, unlock_ff, pdown_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] wdata_ff, rdata_ff;
    logic done_ff, refused_ff, stale_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic [DATA_W-1:0] dq_sync;

    bbfci_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_en(clk_en),
        .din(flash_dq_in),
        .dout(dq_sync)
    );

    // ==========================================================
    // Bus decode
    // ==========================================================
    // Only the low address byte is decoded, so the map repeats every 256 bytes.
    wire addr_phase = hsel && hready && htrans[1];
    wire reg_wr = wr_pend_ff;
    wire wr_ctrl = reg_wr && (wr_addr_ff == REG_CTRL);
    wire wr_addr = reg_wr && (wr_addr_ff == REG_ADDR);
    wire wr_wdata = reg_wr && (wr_addr_ff == REG_WDATA);
    wire wr_status = reg_wr && (wr_addr_ff == REG_STATUS);
    wire busy = (state_ff != ST_IDLE);
    wire start_req = wr_ctrl && hwdata[CTRL_START];
    wire [2:0] req_op = hwdata[CTRL_OP_LSB+2:CTRL_OP_LSB];
    wire op_legal = (req_op <= 3'(OP_ARRAY));
    // While powered down the flash ignores its bus, so starting would be lost.
    wire start_ok = start_req && !busy && !pdown_ff && op_legal;
    wire start_bad = start_req && !start_ok;

    wire [31:0] ctrl_rd = {21'h00_0000, pdown_ff, unlock_ff, byte_mode_ff, 4'h0, op_ff, 1'b0};
    wire [31:0] stat_rd = {28'h000_0000, stale_ff, refused_ff, done_ff, busy};
    // Read data are latched in the address phase, so no wait state is needed.
    wire [31:0] rd_mux =
        (haddr[7:0] == REG_CTRL) ? ctrl_rd :
        (haddr[7:0] == REG_ADDR) ? {13'h0000, addr_ff} :
        (haddr[7:0] == REG_WDATA) ? {16'h0000, wdata_ff} :
        (haddr[7:0] == REG_RDATA) ? {16'h0000, rdata_ff} :
        (haddr[7:0] == REG_STATUS) ? stat_rd : 32'h0000_0000;

    // ==========================================================
    // Bus-cycle selection
    // ==========================================================
    // Step 0 is the command byte; step 1 is the data, confirm or read cycle, or the read-array byte of OP_ARRAY.
    function automatic logic cyc_is_write(input bbfci_op_t op, input logic step);
        unique case (op)
            OP_PROGRAM, OP_ERASE, OP_ARRAY: cyc_is_write = 1'b1;
            default: cyc_is_write = !step;
        endcase
    endfunction

    function automatic logic [7:0] cyc_cmd(input bbfci_op_t op, input logic step);
        unique case (op)
            OP_PROGRAM: cyc_cmd = CMD_WRITE_SETUP;
            // Cmd_a only ever follows the erase setup byte.
            // Setup then confirm.
            OP_ERASE: cyc_cmd = step ? CMD_A : CMD_ERASE_SETUP;
            OP_IDENT: cyc_cmd = IDENTIFY_CMD;
            OP_STATUS: cyc_cmd = STATUS_CMD;
            default: cyc_cmd = CMD_READ_ARRAY;
        endcase
    endfunction

    wire cur_write = cyc_is_write(op_ff, step_ff);
    wire cur_data_cycle = (op_ff == OP_PROGRAM) && step_ff;
    wire [DATA_W-1:0] cmd_word = {8'h00, cyc_cmd(op_ff, step_ff)};
    wire [DATA_W-1:0] prog_word = byte_mode_ff ? {8'h00, wdata_ff[7:0]} : wdata_ff;
    wire [DATA_W-1:0] cur_dq = cur_data_cycle ? prog_word : cmd_word;
    wire [ADDR_W-1:0] cur_addr = (op_ff == OP_IDENT) ? {18'h0_0000, addr_ff[0]} : addr_ff;
    wire start_step = (req_op == 3'(OP_READ)) ? !stale_ff : (req_op == 3'(OP_ARRAY));
    wire strobe_last = cnt_ff == (cur_write ? WE_CYCLES : RD_CYCLES);
    wire rec_last = cnt_ff == REC_CYCLES;
    wire seq_end = (state_ff == ST_RECOVER) && rec_last && step_ff;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: if (start_ok) nxt_state = ST_SETUP;
            ST_SETUP: nxt_state = ST_STROBE;
            ST_STROBE: if (strobe_last) nxt_state = ST_RECOVER;
            ST_RECOVER: if (rec_last) nxt_state = step_ff ? ST_IDLE : ST_SETUP;
        endcase
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    // The count restarts at one on each phase change, so a phase lasts its full count.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            step_ff <= 1'b0;
        end else if (clk_en) begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state != state_ff || state_ff == ST_IDLE) ? 4'h1 : cnt_ff + 4'h1;
            if (state_ff == ST_IDLE) begin
                step_ff <= start_step;
            end else if (state_ff == ST_RECOVER && rec_last) begin
                step_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_ff <= 16'h0000;
        end else if (clk_en && state_ff == ST_STROBE && strobe_last && !cur_write) begin
            rdata_ff <= byte_mode_ff ? {8'h00, dq_sync[7:0]} : dq_sync;
        end
    end

    // The flash leaves array mode after any other command until read-array is sent.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stale_ff <= 1'b0;
        end else if (clk_en) begin
            if (pdown_ff) begin
                stale_ff <= 1'b0;
            end else if (seq_end) begin
                // Status mode after program or erase.
                stale_ff <= (op_ff != OP_READ) && (op_ff != OP_ARRAY);
            end
        end
    end

    // ==========================================================
    // Registers and AHB data phase
    // ==========================================================
    // Writes land in the data phase, when hwdata is valid, one cycle after the address.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else if (clk_en) begin
            wr_pend_ff <= addr_phase && hwrite;
            wr_addr_ff <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_ff <= OP_READ;
            byte_mode_ff <= 1'b0;
            unlock_ff <= 1'b0;
            pdown_ff <= 1'b0;
            addr_ff <= 19'h0_0000;
            wdata_ff <= 16'h0000;
        end else if (clk_en) begin
            if (start_ok) begin
                op_ff <= bbfci_op_t'(req_op);
            end
            // Mode pins cannot change under a running sequence.
            // Unlock held throughout.
            if (wr_ctrl && !busy) begin
                byte_mode_ff <= hwdata[CTRL_BYTE];
                unlock_ff <= hwdata[CTRL_UNLOCK];
                pdown_ff <= hwdata[CTRL_PDOWN];
            end
            if (wr_addr && !busy) begin
                addr_ff <= hwdata[ADDR_W-1:0];
            end
            if (wr_wdata && !busy) begin
                wdata_ff <= hwdata[DATA_W-1:0];
            end
        end
    end

    // Set wins over a clear written in the same cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else if (clk_en) begin
            done_ff <= seq_end || (done_ff && !(wr_status && hwdata[STAT_DONE]));
            refused_ff <= start_bad || (refused_ff && !(wr_status && hwdata[STAT_REFUSED]));
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    wire active = (state_ff != ST_IDLE);
    wire strobing = (state_ff == ST_STROBE);
    bbfci_pins_t pins_c;

    // Every register answers in the cycle it is addressed, so the slave never stalls.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    // One process builds the whole pin bundle, so every field has a single driver.
    always_comb begin
        // Mode pins follow their control bits and never change under a sequence.
        pins_c.reset_powerdown_n = !pdown_ff;
        pins_c.unlock = unlock_ff;
        pins_c.byte_n = !byte_mode_ff;
        // Select stays low across both bus cycles of a two-cycle sequence.
        pins_c.ce_n = !active;
        pins_c.oe_n = !(strobing && !cur_write);
        pins_c.we_n = !(strobing && cur_write);
        // Address and data stand from setup through recovery of each bus cycle.
        pins_c.addr = cur_addr;
        pins_c.dq_out = cur_dq;
        // The data lines are released whenever the host is not writing.
        pins_c.dq_oe = active && cur_write;
    end

    assign flash_pins = pins_c;

endmodule // bbfci_host

`default_nettype wire

// ==== testbench/bbfci_host_assertions.sv ====
/* Pin and bus timing checker for the flash command sequencer.
   Assumes it is bound to bbfci_host and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module bbfci_host_assertions
    import bbfci_pkg::*;
#(
    parameter logic [7:0] IDENTIFY_CMD = IDENTIFY_CMD_DEF
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Watched outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire bbfci_pins_t flash_pins
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire bbfci_pins_t p = flash_pins;
    // ==========================================================
    // Strobes
    // ==========================================================
    we_pulse_a: assert property ($fell(p.we_n) |-> (!p.we_n) [*3] ##1 p.we_n)
        else $error("write strobe width wrong");
    rd_pulse_a: assert property ($fell(p.oe_n) |-> (!p.oe_n) [*6] ##1 p.oe_n)
        else $error("read strobe width wrong");
    write_drive_a: assert property (!p.we_n |-> !p.ce_n && p.dq_oe && p.oe_n)
        else $error("write strobe without select or data");
    read_float_a: assert property (!p.oe_n |-> !p.ce_n && !p.dq_oe && p.we_n)
        else $error("read strobe while driving");
    // Byte mode leaves the upper lines at zero, so a command never leaks there.
    byte_high_a: assert property (!p.byte_n && p.dq_oe |-> p.dq_out[15:8] == 8'h00)
        else $error("upper data lines driven in byte mode");
    // ==========================================================
    // Command order
    // ==========================================================
    erase_pair_a: assert property ($fell(p.we_n) && p.dq_out == 16'h0020 |->
        ##6 ($fell(p.we_n) && p.dq_out == 16'h00D0)) else $error("erase setup not confirmed");
    prog_pair_a: assert property ($fell(p.we_n) && p.dq_out == 16'h0040 |->
        (!p.ce_n) [*7] ##0 $fell(p.we_n)) else $error("write setup not followed by data");
    ident_addr_a: assert property ($fell(p.we_n) && p.dq_out == {8'h00, IDENTIFY_CMD} |->
        ##6 ($fell(p.oe_n) && p.addr[18:1] == 18'h0_0000)) else $error("identify address wrong");
    reset_idle_a: assert property ($rose(hresetn) |-> p.ce_n && p.we_n && !p.dq_oe)
        else $error("pins not idle after reset");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not zero-wait okay");
    cover property ($fell(p.we_n) && p.dq_out == 16'h00D0);
    cover property ($fell(p.we_n) && p.dq_out == 16'h0040);
    cover property ($fell(p.oe_n) && !p.byte_n);
endmodule // bbfci_host_assertions
bind bbfci_host bbfci_host_assertions #(.IDENTIFY_CMD(IDENTIFY_CMD)) bbfci_host_assertions_inst (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .flash_pins(flash_pins));
`default_nettype wire

// ==== testbench/bbfci_flash_model.sv ====
/* Behavioural boot-block flash seen from its pins.
   Assumes a bottom boot block and blocks of 2**BLK_SHIFT addresses; the block map is simplified. */
`timescale 1ns/100ps
`default_nettype none
module bbfci_flash_model
    import bbfci_pkg::*;
#(
    parameter int BLK_SHIFT = 15,
    parameter logic [7:0] MAKER_ID = 8'h5A,
    parameter logic [7:0] PART_ID = 8'hC3,
    parameter logic [7:0] STAT_OK = 8'h80,
    parameter logic [7:0] ERR_FLAG = 8'h10
)
(
    // Pins from the host
    input wire bbfci_pins_t flash_pins,
    // Data toward the host
    output logic [DATA_W-1:0] flash_dq_in
);
    wire bbfci_pins_t p = flash_pins;
    logic [15:0] mem [int];
    logic [15:0] v;
    logic [15:0] last = 16'h0000;
    logic [1:0] mode = 2'h0;
    logic [7:0] pend = 8'h00;
    logic [7:0] stat = STAT_OK;
    int rd_dly = 0;
    wire boot = (p.addr[ADDR_W-1:BLK_SHIFT] == '0);
    always @(posedge p.we_n or negedge p.reset_powerdown_n) begin
        if (!p.reset_powerdown_n) begin
            mode = 2'h0;
            pend = 8'h00;
            stat = STAT_OK;
        end else if (!p.ce_n) begin
            if (pend == CMD_ERASE_SETUP || pend == CMD_WRITE_SETUP ||
                pend == CMD_WRITE_SETUP_ALT) begin
                if ((boot && !p.unlock) || (pend == CMD_ERASE_SETUP && p.dq_out[7:0] != CMD_A))
                    stat = STAT_OK | ERR_FLAG;
                else if (pend == CMD_ERASE_SETUP) begin
                    foreach (mem[k])
                        if ((k >> BLK_SHIFT) == (int'(p.addr) >> BLK_SHIFT)) mem[k] = 16'hFFFF;
                end
                else mem[int'(p.addr)] = p.byte_n ? p.dq_out : {8'h00, p.dq_out[7:0]};
                // status mode once the engine finishes
                mode = 2'h1;
                pend = 8'h00;
            end else begin
                // command byte; the model is never busy
                pend = p.dq_out[7:0];
                if (pend == CMD_READ_ARRAY) mode = 2'h0;
                if (pend == STATUS_CMD_DEF) mode = 2'h1;
                if (pend == IDENTIFY_CMD_DEF) mode = 2'h2;
            end
        end
    end
    always @(p or mode or stat) begin
        if (p.reset_powerdown_n && !p.ce_n && !p.oe_n) begin
            v = (mode == 2'h0) ? (mem.exists(int'(p.addr)) ? mem[int'(p.addr)] : 16'hFFFF)
              : (mode == 2'h1) ? {8'h00, stat} : {8'h00, p.addr[0] ? PART_ID : MAKER_ID};
            if (!p.byte_n) v[15:8] = ~last[15:8];
            last = v;
        end else v = ~last;
        flash_dq_in <= #(rd_dly) v;
    end
endmodule // bbfci_flash_model
`default_nettype wire

// ==== testbench/tb_boot_block_flash_command_interface.sv ====
/* Self-checking bench for the flash command sequencer.
   Assumes the behavioural flash model on the pins and a zero-wait register slave. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_boot_block_flash_command_interface
    import bbfci_pkg::*;
;
    localparam logic [7:0] MAKER_ID = 8'h5A; // Arbitrary value.
    localparam logic [7:0] PART_ID = 8'hC3; // Arbitrary value.
    localparam logic [7:0] STAT_OK = 8'h80;
    localparam logic [7:0] ERR_FLAG = 8'h10;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, s, exp_v;
    logic hreadyout, hresp;
    bbfci_pins_t flash_pins;
    logic [15:0] flash_dq_in, w0, w1;
    logic [18:0] ra;
    logic [31:0] exp_q [$];
    int fail_count = 0, cmp_count = 0, cyc = 0, seed = 69048;
    bbfci_host bbfci_host_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
    bbfci_flash_model #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .STAT_OK(STAT_OK),
        .ERR_FLAG(ERR_FLAG))
        bbfci_flash_model_inst (.flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
    initial begin
        forever #10 hclk = ~hclk;
    end
    // ==========================================================
    // Bus tasks
    // ==========================================================
    task automatic bus_cyc(input logic [7:0] a, input logic wr, input logic [31:0] d,
        input logic chk);
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        if (chk) exp_q.push_back(d);
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= chk;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        s = hrdata;
        rd_phase <= 1'b0;
    endtask
    task automatic run_op(input logic [2:0] op, input logic [2:0] md);
        int n;
        n = 0;
        bus_cyc(REG_CTRL, 1'b1, {21'h00_0000, md, 4'h0, op, 1'b1}, 1'b0);
        do begin
            bus_cyc(REG_STATUS, 1'b0, 32'h0000_0000, 1'b0);
            n++;
        end while (s[STAT_BUSY] !== 1'b0 && n < 100);
        if (s[STAT_BUSY] !== 1'b0) fail_count++;
    endtask
    task automatic access(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d,
        input logic [2:0] md, input logic [31:0] e);
        bus_cyc(REG_ADDR, 1'b1, {13'h0000, a}, 1'b0);
        bus_cyc(REG_WDATA, 1'b1, {16'h0000, d}, 1'b0);
        run_op(op, md);
        if (op != 3'h1 && op != 3'h2) bus_cyc(REG_RDATA, 1'b0, e, 1'b1);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ==========================================================
    // Result watcher and timeout
    // ==========================================================
    always @(posedge hclk) begin
        cyc++;
        if (rd_phase && hreadyout === 1'b1) begin
            exp_v = exp_q.pop_front();
            `CHK("hrdata", exp_v, hrdata)
        end
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end
    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Bit 15 set keeps data apart from command bytes.
        w0 = 16'h8000 | 16'($random(seed));
        w1 = 16'h8000 | 16'($random(seed));
        access(3'h1, 19'h0_9000, w0, 3'h0, 32'h0);
        access(3'h0, 19'h0_9000, 16'h0, 3'h0, {16'h0000, w0});
        access(3'h1, 19'h1_0004, 16'hC3A5, 3'h1, 32'h0);
        access(3'h0, 19'h1_0004, 16'h0, 3'h1, 32'h0000_00A5);
        access(3'h1, 19'h0_0010, w1, 3'h0, 32'h0);
        access(3'h0, 19'h0_0010, 16'h0, 3'h0, 32'h0000_FFFF);
        access(3'h1, 19'h0_0010, w1, 3'h2, 32'h0);
        access(3'h0, 19'h0_0010, 16'h0, 3'h0, {16'h0000, w1});
        access(3'h2, 19'h0_9000, 16'h0, 3'h0, 32'h0);
        access(3'h0, 19'h0_9000, 16'h0, 3'h0, 32'h0000_FFFF);
        access(3'h0, 19'h1_0004, 16'h0, 3'h0, 32'h0000_00A5);
        for (int i = 0; i < 2; i++) begin
            access(3'h3, 19'(i), 16'h0, 3'h0, {24'h00_0000, i ? PART_ID : MAKER_ID});
        end
        access(3'h4, 19'h0_0000, 16'h0, 3'h0, {24'h00_0000, STAT_OK | ERR_FLAG});
        bus_cyc(REG_STATUS, 1'b0, 32'h0000_000A, 1'b1);
        bus_cyc(8'h1C, 1'b0, 32'h0000_0000, 1'b1);
        bus_cyc(REG_STATUS, 1'b1, 32'h0000_000F, 1'b0);
        bus_cyc(REG_CTRL, 1'b1, 32'h0000_0400, 1'b0);
        bus_cyc(REG_CTRL, 1'b1, 32'h0000_0401, 1'b0);
        bus_cyc(REG_STATUS, 1'b0, 32'h0000_0004, 1'b1);
        bus_cyc(REG_CTRL, 1'b1, 32'h0000_0000, 1'b0);
        bbfci_flash_model_inst.rd_dly = 50;
        repeat (4) begin
            w0 = 16'h8000 | 16'($random(seed));
            ra = {2'h1, 17'($random(seed))};
            access(3'h1, ra, w0, 3'h0, 32'h0);
            access(3'h0, ra, 16'h0, 3'h0, {16'h0000, w0});
        end
        print_verdict();
    end
endmodule // tb_boot_block_flash_command_interface
`default_nettype wire
